// >>> design/ccr_pkg.sv
// Purpose : Shared constants and types of the converter configuration bank
// Assumes : 7-bit register address, 8-bit register data
// Notes   : Offsets and field positions live here only

package ccr_pkg;

  // ----------------------------------------------------------------------
  // Widths and types
  // ----------------------------------------------------------------------
  localparam int ADDR_W     = 7;
  localparam int DATA_W     = 8;
  localparam int FRAME_BITS = 16;
  localparam int OBD_REGS   = 3;

  typedef logic [ADDR_W-1:0] ccr_addr_t;
  typedef logic [DATA_W-1:0] ccr_byte_t;
  typedef logic [2:0]        ccr_code_t;

  // ----------------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------------
  localparam ccr_addr_t ADDR_SOFT_RESET = 7'h00;
  localparam ccr_addr_t ADDR_IF_CTRL    = 7'h07;
  localparam ccr_addr_t ADDR_PD_CTRL    = 7'h08;
  localparam ccr_addr_t ADDR_OBD0       = 7'h0A;
  localparam ccr_addr_t ADDR_OBD1       = 7'h0B;
  localparam ccr_addr_t ADDR_OBD2       = 7'h0C;
  localparam ccr_addr_t ADDR_PD_MASK    = 7'h0D;
  localparam ccr_addr_t ADDR_FUSE_LOAD  = 7'h13;

  // ----------------------------------------------------------------------
  // Reset values and field positions
  // ----------------------------------------------------------------------
  localparam ccr_byte_t RESET_BYTE      = 8'h00;
  localparam ccr_code_t RESET_CODE      = 3'h0;
  localparam int BIT_SOFT_RESET         = 0;
  localparam int BIT_FUSE_LOAD          = 0;
  localparam int MAPPER_LSB             = 5;
  localparam int BIT_MODE_OVR_EN        = 3;
  localparam int MODE_SEL_LSB           = 0;
  localparam int BIT_PD_CLKBUF          = 5;
  localparam int BIT_PD_REFAMP          = 4;
  localparam int BIT_PD_A               = 2;
  localparam int BIT_PD_B               = 1;
  localparam int BIT_PD_GLOBAL          = 0;
  localparam int BIT_KEEP_CLKBUF        = 3;
  localparam int BIT_KEEP_REFAMP        = 2;

  // ----------------------------------------------------------------------
  // Mapper and mode encodings
  // ----------------------------------------------------------------------
  localparam ccr_code_t MAP_2W_18_14 = 3'h1;
  localparam ccr_code_t MAP_2W_20_16 = 3'h2;
  localparam ccr_code_t MAP_1W       = 3'h3;
  localparam ccr_code_t MAP_HALF     = 3'h4;
  localparam ccr_code_t MODE_2W      = 3'h3;
  localparam ccr_code_t MODE_1W      = 3'h4;
  localparam ccr_code_t MODE_HALF    = 3'h5;

endpackage

// >>> design/ccr_spi_slave.sv
// Purpose : Serial port front end, 16-bit frames sampled on clk_i
// Assumes : Serial clock at most clk_i/8, enable low for a whole frame
// Notes   : Frame is R/W bit, 7 address bits, 8 data bits, MSB first

`timescale 1ns/1ps

module ccr_spi_slave
  import ccr_pkg::*;
(
  input  wire logic           clk_i,
  input  wire logic           reset_n_i,
  input  wire logic           sclk_i,
  input  wire logic           sen_n_i,
  input  wire logic           sdi_i,
  input  wire ccr_pkg::ccr_byte_t rd_data_i,
  output logic                sdo_o,
  output logic                sdo_oe_n_o,
  output ccr_pkg::ccr_addr_t  addr_o,
  output logic                wr_stb_o,
  output ccr_pkg::ccr_byte_t  wr_data_o
);

  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic [2:0]  sclk_s;
  logic [1:0]  sen_s;
  logic [1:0]  sdi_s;
  logic        rise;
  logic        fall;
  logic        active;
  logic [4:0]  cnt;
  logic [14:0] shreg;
  logic        is_read;
  ccr_byte_t   dout;

  // Third sclk stage is only an edge reference; stage 0 feeds stage 1 only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sclk_s <= 3'h0;
      sen_s  <= 2'h3;
      sdi_s  <= 2'h0;
    end else begin
      sclk_s <= {sclk_s[1:0], sclk_i};
      sen_s  <= {sen_s[0], sen_n_i};
      sdi_s  <= {sdi_s[0], sdi_i};
    end
  end

  assign rise   = sclk_s[1] & ~sclk_s[2];
  assign fall   = ~sclk_s[1] & sclk_s[2];
  assign active = ~sen_s[1];

  // ----------------------------------------------------------------------
  // Receive shifter and bit counter
  // ----------------------------------------------------------------------
  // Counter saturates so extra clocks in one frame cannot start a new one
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cnt   <= 5'h0;
      shreg <= 15'h0;
    end else if (!active) begin
      cnt   <= 5'h0;
    end else if (rise) begin
      shreg <= {shreg[13:0], sdi_s[1]};
      if (cnt != 5'h1F) begin
        cnt <= cnt + 5'h1;
      end
    end
  end

  // Address taken after bit 8, write strobe after bit 16
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      addr_o    <= '0;
      is_read   <= 1'b0;
      wr_stb_o  <= 1'b0;
      wr_data_o <= RESET_BYTE;
    end else begin
      wr_stb_o <= 1'b0;
      if (active && rise && cnt == 5'd7) begin
        addr_o  <= {shreg[5:0], sdi_s[1]};
        is_read <= shreg[6];
      end
      if (active && rise && cnt == 5'd15 && !is_read) begin
        wr_stb_o  <= 1'b1;
        wr_data_o <= {shreg[6:0], sdi_s[1]};
      end
    end
  end

  // ----------------------------------------------------------------------
  // Read data driver, changes on falling serial clock
  // ----------------------------------------------------------------------
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      dout       <= RESET_BYTE;
      sdo_o      <= 1'b0;
      sdo_oe_n_o <= 1'b1;
    end else begin
      if (active && fall) begin
        dout  <= (cnt == 5'd8) ? rd_data_i : {dout[6:0], 1'b0};
        sdo_o <= (cnt == 5'd8) ? rd_data_i[7] : dout[6];
      end
      sdo_oe_n_o <= ~(active && is_read && cnt >= 5'd8 && cnt < 5'd16);
    end
  end

endmodule

// >>> design/ccr_config_regs.sv
// Purpose : Configuration register bank of a dual-channel converter
// Assumes : Host obeys the programming order and writes 0 to reserved bits
// Notes   : Fuse defaults arrive on same-clock inputs, no synchroniser
//
// How it works
// [RULE1] Soft reset bit returns all registers to defaults, then reads zero.
// [RULE2] Mapper codes 1..4 select bit mappings; others unused.
// [RULE3] Written mapper takes effect only at the fuse-load command.
// [RULE4] Host writes mode register, then fuse load, before other writes.
// [RULE5] Fuse mapper applies after reset; field reads 000 until written.
// [RULE6] Override enable gates mode select onto the applied mode.
// [RULE7] Host rewrites buffer disables and related registers on mode change.
// [RULE8] Mode select 3,4,5 mean two-wire, one-wire, half-wire.
// [RULE9] Fuse mode applies after reset; select reads 000 until written.
// [RULE10] Clock buffer power-down bit set powers buffer down.
// [RULE11] Reference amp power-down bit set powers amplifier down.
// [RULE12] Channel A power-down bit set powers channel A down.
// [RULE13] Channel B power-down bit set powers channel B down.
// [RULE14] Global power-down powers down blocks chosen by the mask.
// [RULE15] Each buffer disable bit set powers its output buffer down.
// [RULE16] In global power-down, a mask bit of one keeps its block powered.
// [RULE17] Host writes zero to reserved bits.

`timescale 1ns/1ps

module ccr_config_regs
  import ccr_pkg::*;
(
  input  wire logic                   clk_i,
  input  wire logic                   reset_n_i,
  input  wire logic                   spi_sclk_i,
  input  wire logic                   spi_sen_n_i,
  input  wire logic                   spi_sdi_i,
  output logic                        spi_sdo_o,
  output logic                        spi_sdo_oe_n_o,
  input  wire ccr_pkg::ccr_code_t     fuse_mapper_i,
  input  wire ccr_pkg::ccr_code_t     fuse_mode_i,
  output ccr_pkg::ccr_code_t          interface_bit_mapper_o,
  output ccr_pkg::ccr_code_t          output_mode_o,
  output logic                        clock_buffer_powerdown_o,
  output logic                        reference_amp_powerdown_o,
  output logic                        channel_a_powerdown_o,
  output logic                        channel_b_powerdown_o,
  output logic [DATA_W*OBD_REGS-1:0]  output_buffer_disable_o
);

  // ----------------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------------
  ccr_addr_t  addr;
  logic       wr_stb;
  ccr_byte_t  wr_data;
  ccr_byte_t  rd_data;
  ccr_byte_t  output_interface_ctrl;
  ccr_byte_t  power_down_ctrl;
  ccr_byte_t  powerdown_mask;
  ccr_byte_t  output_buffer_disable [OBD_REGS];
  logic       mapper_written;
  logic       mapper_loaded;
  ccr_code_t  mapper_latched;
  logic       soft_reset;
  logic       fuse_load;
  ccr_code_t  mapper_field;
  ccr_code_t  mode_field;
  logic       global_pd;
  logic [DATA_W*OBD_REGS-1:0] next_obd;

  // ----------------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------------
  ccr_spi_slave u_spi (
    .clk_i      (clk_i),
    .reset_n_i  (reset_n_i),
    .sclk_i     (spi_sclk_i),
    .sen_n_i    (spi_sen_n_i),
    .sdi_i      (spi_sdi_i),
    .rd_data_i  (rd_data),
    .sdo_o      (spi_sdo_o),
    .sdo_oe_n_o (spi_sdo_oe_n_o),
    .addr_o     (addr),
    .wr_stb_o   (wr_stb),
    .wr_data_o  (wr_data)
  );

  // Command decodes; both act in the cycle of the write strobe
  assign soft_reset = wr_stb && addr == ADDR_SOFT_RESET
                      && wr_data[BIT_SOFT_RESET];
  assign fuse_load  = wr_stb && addr == ADDR_FUSE_LOAD
                      && wr_data[BIT_FUSE_LOAD];
  assign mapper_field = output_interface_ctrl[MAPPER_LSB +: 3];
  assign mode_field   = output_interface_ctrl[MODE_SEL_LSB +: 3];
  assign global_pd    = power_down_ctrl[BIT_PD_GLOBAL];

  // ----------------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------------
  // Soft reset wins over everything; soft reset bit itself is never stored
  // Fuse load discards earlier writes except the interface register
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      output_interface_ctrl <= RESET_BYTE;
      power_down_ctrl       <= RESET_BYTE;
      powerdown_mask        <= RESET_BYTE;
      mapper_written        <= 1'b0;
      for (int i = 0; i < OBD_REGS; i++) begin
        output_buffer_disable[i] <= RESET_BYTE;
      end
    end else if (soft_reset) begin
      output_interface_ctrl <= RESET_BYTE; // RULE1
      power_down_ctrl       <= RESET_BYTE; // RULE1
      powerdown_mask        <= RESET_BYTE; // RULE1
      mapper_written        <= 1'b0; // RULE1
      for (int i = 0; i < OBD_REGS; i++) begin
        output_buffer_disable[i] <= RESET_BYTE; // RULE1
      end
    end else if (fuse_load) begin
      power_down_ctrl <= RESET_BYTE;
      powerdown_mask  <= RESET_BYTE;
      for (int i = 0; i < OBD_REGS; i++) begin
        output_buffer_disable[i] <= RESET_BYTE;
      end
    end else if (wr_stb) begin
      unique case (addr)
        ADDR_IF_CTRL: begin
          output_interface_ctrl <= wr_data;
          mapper_written        <= 1'b1; // RULE5
        end
        ADDR_PD_CTRL:  power_down_ctrl          <= wr_data;
        ADDR_PD_MASK:  powerdown_mask           <= wr_data;
        ADDR_OBD0:     output_buffer_disable[0] <= wr_data;
        ADDR_OBD1:     output_buffer_disable[1] <= wr_data;
        ADDR_OBD2:     output_buffer_disable[2] <= wr_data;
        default: ;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Mapper latch, loaded by the fuse-load command; soft reset clears its loaded flag
  // ----------------------------------------------------------------------
  // An unwritten or unused code leaves the fuse mapping in force
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mapper_loaded  <= 1'b0;
      mapper_latched <= RESET_CODE;
    end else if (soft_reset) begin
      mapper_loaded  <= 1'b0; // RULE5
    end else if (fuse_load) begin // RULE3
      mapper_loaded  <= mapper_written
                        && mapper_field inside {MAP_2W_18_14, MAP_2W_20_16,
                                                MAP_1W, MAP_HALF}; // RULE2
      mapper_latched <= mapper_field;
    end
  end

  // ----------------------------------------------------------------------
  // Read mux; reserved and command addresses read zero
  // ----------------------------------------------------------------------
  always_comb begin
    unique case (addr)
      ADDR_IF_CTRL: rd_data = output_interface_ctrl; // RULE5 RULE9
      ADDR_PD_CTRL: rd_data = power_down_ctrl;
      ADDR_PD_MASK: rd_data = powerdown_mask;
      ADDR_OBD0:    rd_data = output_buffer_disable[0];
      ADDR_OBD1:    rd_data = output_buffer_disable[1];
      ADDR_OBD2:    rd_data = output_buffer_disable[2];
      default:      rd_data = RESET_BYTE; // RULE1
    endcase
  end

  // ----------------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------------
  // Per-register buffer disable bits packed low register first
  for (genvar g = 0; g < OBD_REGS; g++) begin : g_obd
    assign next_obd[g*DATA_W +: DATA_W] = output_buffer_disable[g];
  end

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      interface_bit_mapper_o <= RESET_CODE;
      output_mode_o          <= RESET_CODE;
    end else begin
      interface_bit_mapper_o <= mapper_loaded ? mapper_latched
                                              : fuse_mapper_i; // RULE3 RULE5
      // Unused select codes would leave the link undefined, keep fuse mode
      if (output_interface_ctrl[BIT_MODE_OVR_EN] // RULE6
          && mode_field inside {MODE_2W, MODE_1W, MODE_HALF}) begin // RULE8
        output_mode_o <= mode_field;
      end else begin
        output_mode_o <= fuse_mode_i; // RULE9
      end
    end
  end

  // Power controls: a mask bit only protects its block from global pd
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      clock_buffer_powerdown_o  <= 1'b0;
      reference_amp_powerdown_o <= 1'b0;
      channel_a_powerdown_o     <= 1'b0;
      channel_b_powerdown_o     <= 1'b0;
      output_buffer_disable_o   <= '0;
    end else begin
      clock_buffer_powerdown_o  <= power_down_ctrl[BIT_PD_CLKBUF] // RULE10
        | (global_pd & ~powerdown_mask[BIT_KEEP_CLKBUF]); // RULE14 RULE16
      reference_amp_powerdown_o <= power_down_ctrl[BIT_PD_REFAMP] // RULE11
        | (global_pd & ~powerdown_mask[BIT_KEEP_REFAMP]); // RULE14 RULE16
      channel_a_powerdown_o <= power_down_ctrl[BIT_PD_A] | global_pd; // RULE12
      channel_b_powerdown_o <= power_down_ctrl[BIT_PD_B] | global_pd; // RULE13
      output_buffer_disable_o <= next_obd; // RULE15
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  property p_soft_reset;
    @(posedge clk_i) disable iff (!reset_n_i)
      soft_reset |=> ##1 (output_mode_o == $past(fuse_mode_i)
        && !clock_buffer_powerdown_o && !channel_a_powerdown_o
        && output_buffer_disable_o == '0);
  endproperty
  a_soft_reset: assert property (p_soft_reset) // RULE1
    else $error("soft reset left state behind");

  property p_mapper_code;
    @(posedge clk_i) disable iff (!reset_n_i)
      mapper_loaded |-> mapper_latched inside {[3'h1:3'h4]};
  endproperty
  a_mapper_code: assert property (p_mapper_code) // RULE2
    else $error("unused mapper code applied");

  property p_mapper_needs_load;
    @(posedge clk_i) disable iff (!reset_n_i)
      (!fuse_load && !soft_reset) |=> $stable(mapper_loaded)
        && $stable(mapper_latched);
  endproperty
  a_mapper_needs_load: assert property (p_mapper_needs_load) // RULE3
    else $error("mapper changed without fuse load");

  property p_mapper_readback;
    @(posedge clk_i) disable iff (!reset_n_i)
      !mapper_written |-> mapper_field == RESET_CODE && !mapper_loaded;
  endproperty
  a_mapper_readback: assert property (p_mapper_readback) // RULE5
    else $error("mapper field nonzero before any write");

  property p_mode_gate;
    @(posedge clk_i) disable iff (!reset_n_i)
      !output_interface_ctrl[BIT_MODE_OVR_EN]
        |=> output_mode_o == $past(fuse_mode_i);
  endproperty
  a_mode_gate: assert property (p_mode_gate) // RULE6
    else $error("mode applied without override enable");

  property p_mode_decode;
    @(posedge clk_i) disable iff (!reset_n_i)
      (output_interface_ctrl[BIT_MODE_OVR_EN] && mode_field >= 3'h3
        && mode_field <= 3'h5) |=> output_mode_o == $past(mode_field);
  endproperty
  a_mode_decode: assert property (p_mode_decode) // RULE8
    else $error("legal mode select not applied");

  property p_clkbuf;
    @(posedge clk_i) disable iff (!reset_n_i)
      ##1 clock_buffer_powerdown_o == ($past(power_down_ctrl[5])
        || ($past(power_down_ctrl[0]) && !$past(powerdown_mask[3])));
  endproperty
  a_clkbuf: assert property (p_clkbuf) // RULE10 RULE16
    else $error("clock buffer power-down wrong");

  property p_refamp;
    @(posedge clk_i) disable iff (!reset_n_i)
      (power_down_ctrl[4] || (global_pd && !powerdown_mask[2]))
        |=> reference_amp_powerdown_o;
  endproperty
  a_refamp: assert property (p_refamp) // RULE11 RULE14
    else $error("reference amplifier not powered down");

  property p_channels;
    @(posedge clk_i) disable iff (!reset_n_i)
      ##1 channel_a_powerdown_o == ($past(power_down_ctrl[2])
        || $past(global_pd)) && channel_b_powerdown_o
        == ($past(power_down_ctrl[1]) || $past(global_pd));
  endproperty
  a_channels: assert property (p_channels) // RULE12 RULE13
    else $error("channel power-down wrong");

  property p_obd;
    @(posedge clk_i) disable iff (!reset_n_i)
      wr_stb && addr == ADDR_OBD1 && !$past(wr_stb)
        |=> ##1 output_buffer_disable_o[15:8] == $past(wr_data, 2);
  endproperty
  a_obd: assert property (p_obd) // RULE15
    else $error("buffer disable write not driven out");

endmodule

// >>> sim/ccr_spi_host.sv
// Purpose : Serial host model that configures the converter bank
// Assumes : sclk idles low, each level held 8 clk, 16-bit frames
// Notes   : Released data line shows the inverse of its last bit

`timescale 1ns/1ps

module ccr_spi_host
  import ccr_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      sen_n_o,
  output logic      sdi_o
);

  // ----------------------------------------------------------------------
  // Frame engine
  // ----------------------------------------------------------------------
  localparam int HALF = 8;  // Double the 4 clk minimum for margin

  initial begin
    sclk_o  = 1'b0;
    sen_n_o = 1'b1;
    sdi_o   = 1'b0;
  end

  // One whole frame; read bits are taken on sclk rising edges
  task automatic xfer(input logic rd, input ccr_addr_t addr,
                      input ccr_byte_t wdata, output ccr_byte_t rdata);
    logic [FRAME_BITS-1:0] frame;
    frame = {rd, addr, wdata};
    rdata = RESET_BYTE;
    @(posedge clk_i);
    sen_n_o <= 1'b0;
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      sdi_o <= frame[i];
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b1;
      if (i < DATA_W) rdata[i] = sdo_i;
      repeat (HALF) @(posedge clk_i);
      sclk_o <= 1'b0;
    end
    repeat (HALF) @(posedge clk_i);
    sen_n_o <= 1'b1;
    sdi_o   <= ~frame[0];  // Stale data must not look valid
    repeat (HALF) @(posedge clk_i);  // Gap above the 4 clk minimum
  endtask
endmodule

// >>> sim/converter_config_registers_bench.sv
// Purpose : Self-checking bench of the configuration register bank
// Assumes : Host model frames, writes settle within 8 clk of frame end
// Notes   : Random data from an LFSR seeded with 52675

`timescale 1ns/1ps

module converter_config_registers_bench;
  import ccr_pkg::*;

  logic                       clk_i;
  logic                       reset_n_i;
  logic                       sclk, sen_n, sdi, sdo, sdo_oe_n, sdo_pin;
  ccr_code_t                  fuse_map, fuse_mode, mapper, mode, exp_map;
  logic                       pd_clk, pd_ref, pd_a, pd_b;
  logic [DATA_W*OBD_REGS-1:0] obd, exp_obd;
  ccr_byte_t                  rd, v, pd_reg, mask, b;
  logic [15:0]                lfsr;
  int                         fail_count, n_tests;

  // Every stored register and the soft reset address, for the soft reset read-back sweep
  localparam ccr_addr_t ADDR_LIST [7] = '{ADDR_SOFT_RESET, ADDR_IF_CTRL,
    ADDR_PD_CTRL, ADDR_OBD0, ADDR_OBD1, ADDR_OBD2, ADDR_PD_MASK};

  // ----------------------------------------------------------------------
  // Design, host and clock
  // ----------------------------------------------------------------------
  // Undriven sdo shows the inverse so a stale bit cannot pass
  assign sdo_pin = sdo_oe_n ? ~sdo : sdo;

  ccr_config_regs ccr_config_regs_inst (
    .clk_i(clk_i), .reset_n_i(reset_n_i), .spi_sclk_i(sclk),
    .spi_sen_n_i(sen_n), .spi_sdi_i(sdi), .spi_sdo_o(sdo),
    .spi_sdo_oe_n_o(sdo_oe_n), .fuse_mapper_i(fuse_map),
    .fuse_mode_i(fuse_mode), .interface_bit_mapper_o(mapper),
    .output_mode_o(mode), .clock_buffer_powerdown_o(pd_clk),
    .reference_amp_powerdown_o(pd_ref), .channel_a_powerdown_o(pd_a),
    .channel_b_powerdown_o(pd_b), .output_buffer_disable_o(obd));

  ccr_spi_host host (.clk_i(clk_i), .sdo_i(sdo_pin), .sclk_o(sclk),
                     .sen_n_o(sen_n), .sdi_o(sdi));

  always #2.5 clk_i = ~clk_i;

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [15:0] lfsr_next(logic [15:0] x);
    return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
  endfunction

  // Expected {clkbuf, refamp, chA, chB} power-down levels
  function automatic logic [3:0] exp_pd(ccr_byte_t r, ccr_byte_t m);
    logic g;
    g = r[BIT_PD_GLOBAL];
    return {r[BIT_PD_CLKBUF] | (g & ~m[BIT_KEEP_CLKBUF]),
            r[BIT_PD_REFAMP] | (g & ~m[BIT_KEEP_REFAMP]),
            r[BIT_PD_A] | g, r[BIT_PD_B] | g};
  endfunction

  task automatic rnd(output ccr_byte_t x);
    lfsr = lfsr_next(lfsr);
    x = lfsr[7:0];
  endtask

  task automatic chk_rd(input ccr_byte_t got, input ccr_byte_t exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: read %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_port(input logic [23:0] got, input logic [23:0] exp);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: port %h expected %h", $time, got, exp);
    end
  endtask

  // Write, then let the strobe and the applied outputs land
  task automatic wr(input ccr_addr_t a, input ccr_byte_t d);
    host.xfer(1'b0, a, d, rd);
    repeat (8) @(posedge clk_i);
  endtask

  task automatic rd_reg(input ccr_addr_t a);
    host.xfer(1'b1, a, RESET_BYTE, rd);
  endtask

  task automatic wrap_up();
    $display("Comparisons %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------------
  // Watchdog: about twice the expected run
  // ----------------------------------------------------------------------
  initial begin
    repeat (40000) @(posedge clk_i);
    fail_count++;
    $display("Error at %0t: watchdog %h expected %h", $time, 1'b1, 1'b0);
    wrap_up();
  end

  // ----------------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    reset_n_i = 1'b0;
    fail_count = 0;
    n_tests = 0;
    lfsr = 16'hCDC3;
    rnd(v);
    fuse_map <= ccr_code_t'(v[1:0]) + MAP_2W_18_14;  // Fuse codes 1..4
    fuse_mode <= ccr_code_t'(v[3:2] % 3) + MODE_2W;
    repeat (4) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (4) @(posedge clk_i);
    chk_port(24'({mapper, mode, pd_clk, pd_ref, pd_a, pd_b}),
             24'({fuse_map, fuse_mode, 4'h0}));
    chk_port(obd, 24'h0);
    rd_reg(ADDR_IF_CTRL);
    chk_rd(rd, RESET_BYTE);
    $display("Reset defaults test done");
    // Mapper codes 1..4, override off on pass 3, unused codes 7 on pass 4
    exp_map = fuse_map;
    for (int i = 0; i < 5; i++) begin
      b = {3'(i + 1), 1'b0, (i < 3), (i < 3) ? 3'(i + 3) : MODE_HALF};
      if (i == 4) begin
        b = 8'hEF;  // Unused codes must leave the fuse settings in force
      end
      wr(ADDR_IF_CTRL, b);
      chk_port(24'(mapper), 24'(exp_map));
      wr(ADDR_FUSE_LOAD, 8'h01);
      exp_map = (i == 4) ? fuse_map : b[7:5];
      chk_port(24'(mapper), 24'(exp_map));
      chk_port(24'(mode),
               24'(b[3] && i < 4 ? b[2:0] : fuse_mode));
      rd_reg(ADDR_IF_CTRL);
      chk_rd(rd, b);
      // Mode changed, so buffer disables are written again
      for (int k = 0; k < OBD_REGS; k++) begin
        rnd(v);
        wr(ccr_addr_t'(ADDR_OBD0 + k), v);
        exp_obd[k*8 +: 8] = v;
      end
      chk_port(obd, exp_obd);
      rd_reg(ccr_addr_t'(ADDR_OBD0 + i % 3));
      chk_rd(rd, exp_obd[(i % 3)*8 +: 8]);
    end
    $display("Mapper and mode test done");
    // Per-block power-downs, reserved bits kept zero
    for (int j = 0; j < 6; j++) begin
      rnd(v);
      pd_reg = v & 8'h36;
      wr(ADDR_PD_CTRL, pd_reg);
      chk_port(24'({pd_clk, pd_ref, pd_a, pd_b}),
               24'(exp_pd(pd_reg, 8'h00)));
    end
    rd_reg(ADDR_PD_CTRL);
    chk_rd(rd, pd_reg);
    // Global power-down under each mask pair
    for (int j = 0; j < 4; j++) begin
      mask = {4'h0, 2'(j), 2'b00};
      wr(ADDR_PD_MASK, mask);
      wr(ADDR_PD_CTRL, 8'h01);
      chk_port(24'({pd_clk, pd_ref, pd_a, pd_b}),
               24'(exp_pd(8'h01, mask)));
    end
    $display("Power-down test done");
    // Unmapped and write-only places read zero
    wr(7'h55, 8'hA5);
    rd_reg(7'h55);
    chk_rd(rd, RESET_BYTE);
    rd_reg(ADDR_FUSE_LOAD);
    chk_rd(rd, RESET_BYTE);
    $display("Unmapped test done");
    // Soft reset with everything set
    wr(ADDR_SOFT_RESET, 8'h01);
    chk_port({mapper, mode, pd_clk, pd_ref, pd_a, pd_b, 14'h0},
             {fuse_map, fuse_mode, 18'h0});
    chk_port(obd, 24'h0);
    foreach (ADDR_LIST[k]) begin
      rd_reg(ADDR_LIST[k]);
      chk_rd(rd, RESET_BYTE);
    end
    $display("Soft reset test done");
    wrap_up();
  end
endmodule
